// >>> hdl/alsr_defs.vh
`ifndef ALSR_DEFS_VH
`define ALSR_DEFS_VH

// register offsets on the serial control bus
`define ALSR_AUDIO_CFG_ADDR      8'h55
`define ALSR_LINK_STS_ADDR       8'h5A

// reset values
`define ALSR_AUDIO_CFG_RST       8'h0C
`define ALSR_LINK_STS_RST        8'h00

// audio_configuration fields
`define ALSR_AC_TDM_CONV_BIT     7
`define ALSR_AC_HDMI_I2S_BIT     6
`define ALSR_AC_RST_TYPE_BIT     3
`define ALSR_AC_RST_AIF_BIT      2
`define ALSR_AC_RST_AVI_BIT      1
`define ALSR_AC_RST_ACR_BIT      0
`define ALSR_AC_WR_MASK          8'hCF

// link_and_input_status fields
`define ALSR_LS_LINK_RDY_BIT     7
`define ALSR_LS_TX_ACTIVE_BIT    6
`define ALSR_LS_PORT_HI_BIT      5
`define ALSR_LS_PORT_LO_BIT      4
`define ALSR_LS_TMDS_BIT         3
`define ALSR_LS_PLL_LOCK_BIT     2
`define ALSR_LS_FREQ_BIT         0

// bridge audio mode value meaning hdmi audio only
`define ALSR_AUDIO_MODE_HDMI     2'h0

// port mode codes
`define ALSR_PORT_DUAL           2'h0
`define ALSR_PORT_SINGLE0        2'h1
`define ALSR_PORT_SINGLE1        2'h2
`define ALSR_PORT_REPLICATE      2'h3

// synchronised status vector layout
`define ALSR_SYNC_W              11
`define ALSR_SY_LINK_DET         0
`define ALSR_SY_CAPS_DONE        1
`define ALSR_SY_TX_ACTIVE        2
`define ALSR_SY_RX_LOCKED        3
`define ALSR_SY_INPUT_VALID      4
`define ALSR_SY_MODE_OK          5
`define ALSR_SY_PORT_LO          6
`define ALSR_SY_PORT_HI          7
`define ALSR_SY_TMDS             8
`define ALSR_SY_PLL_LOCK         9
`define ALSR_SY_FREQ             10

`endif

// >>> hdl/alsr_audio_link_regs.v
// Contract
// R1 - audio config bit 7 enables tdm conversion
// R2 - tdm conversion clock feeds deserializer transfer
// R3 - bit 6 drives hdmi audio onto i2s pins
// R4 - bit 6 ignored unless audio mode 00
// R5 - bit 3: fifo reset on audio type change
// R6 - bit 2: fifo reset on audio infoframe checksum change
// R7 - bit 1: fifo reset on video infoframe checksum change
// R8 - bit 0: fifo reset on n/cts change
// R9 - bit 7: downstream link detected and capabilities known
// R10 - bit 6: transmitter active and receiver locked
// R11 - bit 6 clear until input valid, mode correct
// R12 - bits 5:4 port mode while bit 6 set
// R13 - bit 3: tmds data being recovered
// R14 - bit 2: hdmi pll locked
// R15 - bit 0: input clock frequency stable
// R16 - status writes, reserved bits ignored; reserved reads zero
`timescale 1ns/1ps
`include "alsr_defs.vh"

module alsr_audio_link_regs (
  input  wire        core_clk,              // hdmi input clock domain, 100 MHz
  input  wire        sys_rst,               // synchronous reset, active high
  // serial control bus register port
  input  wire [7:0]  reg_addr,              // register offset
  input  wire        reg_wr_en,             // one-cycle write strobe
  input  wire [7:0]  reg_wr_data,           // write data
  input  wire        reg_rd_en,             // one-cycle read strobe
  output reg  [7:0]  reg_rd_data,           // read data, valid the cycle after reg_rd_en
  output reg         reg_rd_valid,          // one-cycle pulse with reg_rd_data
  // bridge configuration
  input  wire [1:0]  bridge_audio_mode,     // audio mode field from bridge configuration
  // hdmi audio packet decoder, same clock
  input  wire        audio_type_valid,      // strobe with audio_type
  input  wire [3:0]  audio_type,            // received audio coding type
  input  wire        aif_valid,             // strobe with aif_checksum
  input  wire [7:0]  aif_checksum,          // audio infoframe checksum
  input  wire        avi_valid,             // strobe with avi_checksum
  input  wire [7:0]  avi_checksum,          // video information infoframe checksum
  input  wire        acr_valid,             // strobe with acr_n and acr_cts
  input  wire [19:0] acr_n,                 // clock regeneration n value
  input  wire [19:0] acr_cts,               // clock regeneration cts value
  // hdmi extracted audio, same clock
  input  wire        hdmi_i2s_sck,          // extracted bit clock level
  input  wire        hdmi_i2s_ws,           // extracted word select
  input  wire [3:0]  hdmi_i2s_sd,           // extracted serial data lanes
  // status from other domains and analog blocks
  input  wire        link_detected,         // valid downstream connection seen
  input  wire        link_caps_done,        // downstream capabilities determined
  input  wire        tx_running,            // serial transmitter active
  input  wire        remote_locked,         // remote receiver locked to tx clock
  input  wire        input_detected,        // valid video input detected
  input  wire        tx_mode_settled,       // single or dual mode entered correctly
  input  wire [1:0]  tx_port_mode,          // current port mode code
  input  wire        tmds_recovering,       // tmds receiver recovering data
  input  wire        hdmi_pll_locked,       // hdmi pll lock
  input  wire        input_frequency_settled_raw,       // frequency detector reports stable
  // controls to the audio path
  output reg         tdm_conv_en,           // tdm to parallel conversion enable
  output reg         audio_clk_sel_tdm,     // 1: use conversion clock for audio transfer
  output reg         hdmi_fifo_reset,       // one-cycle audio fifo reset pulse
  output reg         i2s_out_en,            // i2s pins carry hdmi audio
  output reg         i2s_sck_out,           // i2s bit clock pin
  output reg         i2s_ws_out,            // i2s word select pin
  output reg  [3:0]  i2s_sd_out             // i2s data pins
);

  reg  [7:0]  audio_cfg_q;
  reg  [7:0]  link_sts_q;
  wire [7:0]  link_sts_d;

  // ---------------------------------------------------------------------------
  // status synchronisers: three stages, value moves only when stages 2 and 3 agree
  // ---------------------------------------------------------------------------
  wire [`ALSR_SYNC_W-1:0] sync_in;
  reg  [`ALSR_SYNC_W-1:0] sync1_q;
  reg  [`ALSR_SYNC_W-1:0] sync2_q;
  reg  [`ALSR_SYNC_W-1:0] sync3_q;
  reg  [`ALSR_SYNC_W-1:0] sts_q;

  assign sync_in[`ALSR_SY_LINK_DET]    = link_detected;
  assign sync_in[`ALSR_SY_CAPS_DONE]   = link_caps_done;
  assign sync_in[`ALSR_SY_TX_ACTIVE]   = tx_running;
  assign sync_in[`ALSR_SY_RX_LOCKED]   = remote_locked;
  assign sync_in[`ALSR_SY_INPUT_VALID] = input_detected;
  assign sync_in[`ALSR_SY_MODE_OK]     = tx_mode_settled;
  assign sync_in[`ALSR_SY_PORT_LO]     = tx_port_mode[0];
  assign sync_in[`ALSR_SY_PORT_HI]     = tx_port_mode[1];
  assign sync_in[`ALSR_SY_TMDS]        = tmds_recovering;
  assign sync_in[`ALSR_SY_PLL_LOCK]    = hdmi_pll_locked;
  assign sync_in[`ALSR_SY_FREQ]        = input_frequency_settled_raw;

  genvar gi;
  generate
    for (gi = 0; gi < `ALSR_SYNC_W; gi = gi + 1)
    begin : g_sync
      always @(posedge core_clk)
      begin
        if (sys_rst)
        begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
          sync3_q[gi] <= 1'b0;
          sts_q[gi]   <= 1'b0;
        end
        else
        begin
          sync1_q[gi] <= sync_in[gi];
          sync2_q[gi] <= sync1_q[gi];
          sync3_q[gi] <= sync2_q[gi];
          // a one-cycle disagreement is treated as a glitch and held off
          if (sync2_q[gi] == sync3_q[gi])
            sts_q[gi] <= sync3_q[gi];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // link and input status assembly
  // ---------------------------------------------------------------------------
  wire link_ready_w;
  wire tx_ok_w;
  wire [1:0] port_mode_w;

  assign link_ready_w = sts_q[`ALSR_SY_LINK_DET] & sts_q[`ALSR_SY_CAPS_DONE]; // see R9
  // port mode is shown only while tx_ok_w (bit 6) is set; lanes may skew by a cycle
  assign tx_ok_w = sts_q[`ALSR_SY_TX_ACTIVE] & sts_q[`ALSR_SY_RX_LOCKED] // see R10
                 & sts_q[`ALSR_SY_INPUT_VALID] & sts_q[`ALSR_SY_MODE_OK]; // see R11
  assign port_mode_w = tx_ok_w ? {sts_q[`ALSR_SY_PORT_HI], sts_q[`ALSR_SY_PORT_LO]}
                               : `ALSR_PORT_DUAL; // see R12

  assign link_sts_d = {link_ready_w,                 // see R9
                       tx_ok_w,                      // see R10
                       port_mode_w,                  // see R12
                       sts_q[`ALSR_SY_TMDS],         // see R13
                       sts_q[`ALSR_SY_PLL_LOCK],     // see R14
                       1'b0,                         // see R16
                       sts_q[`ALSR_SY_FREQ]};        // see R15

  always @(posedge core_clk)
  begin
    if (sys_rst)
      link_sts_q <= `ALSR_LINK_STS_RST;
    else
      link_sts_q <= link_sts_d;
  end

  // ---------------------------------------------------------------------------
  // register port
  // ---------------------------------------------------------------------------
  always @(posedge core_clk)
  begin
    if (sys_rst)
      audio_cfg_q <= `ALSR_AUDIO_CFG_RST;
    else if (reg_wr_en && reg_addr == `ALSR_AUDIO_CFG_ADDR)
      audio_cfg_q <= reg_wr_data & `ALSR_AC_WR_MASK; // see R16
    // writes to the status offset and unmapped offsets fall through: see R16
  end

  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      reg_rd_data  <= 8'h00;
      reg_rd_valid <= 1'b0;
    end
    else
    begin
      reg_rd_valid <= reg_rd_en;
      if (reg_rd_en)
      begin
        case (reg_addr)
          `ALSR_AUDIO_CFG_ADDR: reg_rd_data <= audio_cfg_q & `ALSR_AC_WR_MASK; // see R16
          `ALSR_LINK_STS_ADDR:  reg_rd_data <= link_sts_q;
          default:              reg_rd_data <= 8'h00;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------------------
  // audio path controls
  // ---------------------------------------------------------------------------
  wire i2s_en_w;

  assign i2s_en_w = audio_cfg_q[`ALSR_AC_HDMI_I2S_BIT]
                  & (bridge_audio_mode == `ALSR_AUDIO_MODE_HDMI); // see R4

  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      tdm_conv_en       <= 1'b0;
      audio_clk_sel_tdm <= 1'b0;
      i2s_out_en        <= 1'b0;
      i2s_sck_out       <= 1'b0;
      i2s_ws_out        <= 1'b0;
      i2s_sd_out        <= 4'h0;
    end
    else
    begin
      tdm_conv_en       <= audio_cfg_q[`ALSR_AC_TDM_CONV_BIT]; // see R1
      // select only; the clock mux itself must be glitch-free outside this block
      audio_clk_sel_tdm <= audio_cfg_q[`ALSR_AC_TDM_CONV_BIT]; // see R2
      i2s_out_en        <= i2s_en_w; // see R3
      // pins idle low when not carrying hdmi audio
      i2s_sck_out       <= i2s_en_w & hdmi_i2s_sck; // see R3
      i2s_ws_out        <= i2s_en_w & hdmi_i2s_ws; // see R3
      i2s_sd_out        <= i2s_en_w ? hdmi_i2s_sd : 4'h0; // see R3
    end
  end

  // ---------------------------------------------------------------------------
  // change detectors; first value after reset only primes, it is no change
  // ---------------------------------------------------------------------------
  reg  [3:0]  type_last_q;
  reg  [7:0]  aif_last_q;
  reg  [7:0]  avi_last_q;
  reg  [39:0] acr_last_q;
  reg  [3:0]  seen_q;
  wire [3:0]  change_w;

  assign change_w[0] = acr_valid & seen_q[0] & ({acr_n, acr_cts} != acr_last_q);
  assign change_w[1] = avi_valid & seen_q[1] & (avi_checksum != avi_last_q);
  assign change_w[2] = aif_valid & seen_q[2] & (aif_checksum != aif_last_q);
  assign change_w[3] = audio_type_valid & seen_q[3] & (audio_type != type_last_q);

  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      type_last_q <= 4'h0;
      aif_last_q  <= 8'h00;
      avi_last_q  <= 8'h00;
      acr_last_q  <= 40'h00_0000_0000;
      seen_q      <= 4'h0;
    end
    else
    begin
      if (acr_valid)
      begin
        acr_last_q <= {acr_n, acr_cts};
        seen_q[0]  <= 1'b1;
      end
      if (avi_valid)
      begin
        avi_last_q <= avi_checksum;
        seen_q[1]  <= 1'b1;
      end
      if (aif_valid)
      begin
        aif_last_q <= aif_checksum;
        seen_q[2]  <= 1'b1;
      end
      if (audio_type_valid)
      begin
        type_last_q <= audio_type;
        seen_q[3]   <= 1'b1;
      end
    end
  end

  // enable bits 3:0 line up with change_w 3:0
  always @(posedge core_clk)
  begin
    if (sys_rst)
      hdmi_fifo_reset <= 1'b0;
    else
      hdmi_fifo_reset <= (change_w[3] & audio_cfg_q[`ALSR_AC_RST_TYPE_BIT])   // see R5
                       | (change_w[2] & audio_cfg_q[`ALSR_AC_RST_AIF_BIT])    // see R6
                       | (change_w[1] & audio_cfg_q[`ALSR_AC_RST_AVI_BIT])    // see R7
                       | (change_w[0] & audio_cfg_q[`ALSR_AC_RST_ACR_BIT]);   // see R8
  end

endmodule // alsr_audio_link_regs

// >>> tb/alsr_audio_link_regs_asserts.sv
`timescale 1ns/1ps
module alsr_audio_link_regs_asserts (
  input logic       core_clk,          // clock
  input logic       sys_rst,           // reset
  input logic [7:0] reg_addr,          // offset
  input logic       reg_wr_en,         // write
  input logic [7:0] reg_wr_data,       // wdata
  input logic       reg_rd_en,         // read
  input logic [7:0] reg_rd_data,       // rdata
  input logic       reg_rd_valid,      // rvalid
  input logic [1:0] bridge_audio_mode, // mode
  input logic       audio_type_valid,  // strobe
  input logic       aif_valid,         // strobe
  input logic       avi_valid,         // strobe
  input logic       acr_valid,         // strobe
  input logic       hdmi_i2s_ws,       // ws in
  input logic [3:0] hdmi_i2s_sd,       // sd in
  input logic       tdm_conv_en,       // tdm
  input logic       audio_clk_sel_tdm, // clk sel
  input logic       hdmi_fifo_reset,   // fifo rst
  input logic       i2s_out_en,        // i2s en
  input logic       i2s_sck_out,       // sck
  input logic       i2s_ws_out,        // ws
  input logic [3:0] i2s_sd_out         // sd
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence s_wcfg; reg_wr_en && reg_addr == 8'h55; endsequence
  sequence s_rcfg; reg_rd_en && reg_addr == 8'h55; endsequence
  sequence s_rsts; reg_rd_en && reg_addr == 8'h5A; endsequence
  sequence s_on3; i2s_out_en [*3]; endsequence
  // expects exactly two cycles from write to control output
  property p_tdm; (s_wcfg ##1 !(reg_wr_en && reg_addr == 8'h55)) |-> ##1 tdm_conv_en == $past(reg_wr_data[7], 2);
  endproperty
  property p_clksel; audio_clk_sel_tdm == tdm_conv_en; endproperty
  property p_mode; i2s_out_en |-> $past(bridge_audio_mode) == 2'h0; endproperty
  property p_off; !i2s_out_en |-> {i2s_sck_out, i2s_ws_out, i2s_sd_out} == 6'h00; endproperty
  property p_copy; s_on3 |-> i2s_sd_out == $past(hdmi_i2s_sd) && i2s_ws_out == $past(hdmi_i2s_ws); endproperty
  property p_cause; hdmi_fifo_reset |-> $past(audio_type_valid || aif_valid || avi_valid || acr_valid); endproperty
  property p_rdv; reg_rd_valid == $past(reg_rd_en); endproperty
  property p_resv_cfg; s_rcfg |=> reg_rd_data[5:4] == 2'h0; endproperty
  property p_resv_sts; s_rsts |=> reg_rd_data[1] == 1'h0; endproperty
  property p_port; (s_rsts ##1 !reg_rd_data[6]) |-> reg_rd_data[5:4] == 2'h0; endproperty
  a_tdm: assert property (p_tdm) else $error("tdm enable does not follow write");
  a_clksel: assert property (p_clksel) else $error("clock select differs from tdm enable");
  a_mode: assert property (p_mode) else $error("i2s enabled outside hdmi audio mode");
  a_off: assert property (p_off) else $error("i2s pins active while disabled");
  a_copy: assert property (p_copy) else $error("i2s pins do not copy hdmi audio");
  a_cause: assert property (p_cause) else $error("fifo reset without strobe");
  a_rdv: assert property (p_rdv) else $error("read valid not one cycle after read");
  a_resv_cfg: assert property (p_resv_cfg) else $error("config reserved bits nonzero");
  a_resv_sts: assert property (p_resv_sts) else $error("status reserved bit nonzero");
  a_port: assert property (p_port) else $error("port mode shown without transmit");
endmodule // alsr_audio_link_regs_asserts

bind alsr_audio_link_regs alsr_audio_link_regs_asserts u_chk (
  .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
  .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid), .bridge_audio_mode(bridge_audio_mode),
  .audio_type_valid(audio_type_valid), .aif_valid(aif_valid), .avi_valid(avi_valid), .acr_valid(acr_valid),
  .hdmi_i2s_ws(hdmi_i2s_ws), .hdmi_i2s_sd(hdmi_i2s_sd), .tdm_conv_en(tdm_conv_en), .audio_clk_sel_tdm(audio_clk_sel_tdm),
  .hdmi_fifo_reset(hdmi_fifo_reset), .i2s_out_en(i2s_out_en), .i2s_sck_out(i2s_sck_out), .i2s_ws_out(i2s_ws_out),
  .i2s_sd_out(i2s_sd_out));

// >>> tb/alsr_audio_link_regs_tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; \
  $display("Error at %0t: got %h expected %h", $time, g, e); end end

module alsr_audio_link_regs_tb_top;
  logic        core_clk, sys_rst, reg_wr_en, reg_rd_en, reg_rd_valid, tdm_conv_en, audio_clk_sel_tdm;
  logic        hdmi_fifo_reset, i2s_out_en, i2s_sck_out, i2s_ws_out, hdmi_i2s_sck, hdmi_i2s_ws;
  logic        audio_type_valid, aif_valid, avi_valid, acr_valid;
  logic        link_detected, link_caps_done, tx_running, remote_locked, input_detected, tx_mode_settled;
  logic        tmds_recovering, hdmi_pll_locked, input_frequency_settled_raw;
  logic [1:0]  bridge_audio_mode, tx_port_mode;
  logic [3:0]  audio_type, hdmi_i2s_sd, i2s_sd_out;
  logic [7:0]  reg_addr, reg_wr_data, reg_rd_data, aif_checksum, avi_checksum;
  logic [19:0] acr_n, acr_cts;
  int          errors, n_tests;

  alsr_audio_link_regs dut (.*);

  always #5 core_clk = ~core_clk;

  task automatic wrap_up;
    $display("errors %0d comparisons %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr    <= a;
    reg_wr_data <= d;
    reg_wr_en   <= 1'h1;
    @(posedge core_clk);
    reg_wr_en   <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_rd_en <= 1'h1;
    @(posedge core_clk);
    reg_rd_en <= 1'h0;
    #1;
    `CHK(reg_rd_valid, 1'h1)
    `CHK(reg_rd_data, e)
  endtask

  // one strobe on source k; all payloads move together, only the strobe selects
  task automatic ev(input int k, input logic [39:0] v, input logic p);
    @(posedge core_clk);
    {audio_type, aif_checksum, avi_checksum} <= {v[3:0], v[7:0], v[7:0]};
    {acr_n, acr_cts} <= v;
    {audio_type_valid, aif_valid, avi_valid, acr_valid} <= 4'h8 >> k;
    @(posedge core_clk);
    {audio_type_valid, aif_valid, avi_valid, acr_valid} <= 4'h0;
    #1;
    `CHK(hdmi_fifo_reset, p)
  endtask

  // status inputs pass a synchroniser, so wait well past its depth
  task automatic st(input logic [10:0] v, input logic [7:0] e);
    @(posedge core_clk);
    {link_detected, link_caps_done, tx_running, remote_locked, input_detected, tx_mode_settled,
     tx_port_mode, tmds_recovering, hdmi_pll_locked, input_frequency_settled_raw} <= v;
    repeat (8) @(posedge core_clk);
    rd(8'h5A, e);
  endtask

  task automatic t_reset;
    rd(8'h55, 8'h0C);
    rd(8'h5A, 8'h00);
    `CHK({tdm_conv_en, i2s_out_en, hdmi_fifo_reset}, 3'h0)
  endtask

  task automatic t_cfg;
    wr(8'h55, 8'hFF);
    wr(8'h5A, 8'hFF);
    rd(8'h55, 8'hCF);
    rd(8'h5A, 8'h00);
    rd(8'h56, 8'h00);
    `CHK({tdm_conv_en, audio_clk_sel_tdm}, 2'h3)
    wr(8'h55, 8'h4C);
    rd(8'h55, 8'h4C);
    `CHK({tdm_conv_en, audio_clk_sel_tdm}, 2'h0)
  endtask

  task automatic t_i2s;
    @(posedge core_clk);
    bridge_audio_mode <= 2'h1;
    {hdmi_i2s_sck, hdmi_i2s_ws, hdmi_i2s_sd} <= 6'h3A;
    repeat (3) @(posedge core_clk);
    #1;
    `CHK({i2s_out_en, i2s_sck_out, i2s_ws_out, i2s_sd_out}, 7'h00)
    @(posedge core_clk);
    bridge_audio_mode <= 2'h0;
    repeat (3) @(posedge core_clk);
    #1;
    `CHK({i2s_out_en, i2s_sck_out, i2s_ws_out, i2s_sd_out}, 7'h7A)
    @(posedge core_clk);
    hdmi_i2s_sd <= 4'h5;
    @(posedge core_clk);
    #1;
    `CHK(i2s_sd_out, 4'h5)
  endtask

  task automatic t_events;
    wr(8'h55, 8'h00);
    for (int k = 0; k < 4; k++)
    begin
      ev(k, 40'h1, 1'h0);
      ev(k, 40'h2, 1'h0);
      wr(8'h55, 8'h08 >> k);
      ev(k, 40'h3, 1'h1);
      ev(k, 40'h3, 1'h0);
      ev(k, 40'h10_0003, k == 3);
      wr(8'h55, 8'h00);
    end
  endtask

  task automatic t_status;
    for (int m = 0; m < 4; m++)
      st({6'h3F, m[1:0], 3'h7}, {2'h3, m[1:0], 4'hD});
    st({6'h3D, 2'h3, 3'h7}, 8'h8D);
    st({6'h3E, 2'h3, 3'h7}, 8'h8D);
    st({6'h3B, 2'h3, 3'h7}, 8'h8D);
    st({6'h2F, 2'h3, 3'h7}, 8'h7D);
    st({6'h00, 2'h3, 3'h4}, 8'h08);
    st({6'h00, 2'h3, 3'h2}, 8'h04);
    st({6'h00, 2'h3, 3'h1}, 8'h01);
  endtask

  initial
  begin
    core_clk = 1'h0;
    sys_rst  = 1'h1;
    {reg_addr, reg_wr_en, reg_wr_data, reg_rd_en, bridge_audio_mode, audio_type_valid, audio_type} = '0;
    {aif_valid, aif_checksum, avi_valid, avi_checksum, acr_valid, acr_n, acr_cts} = '0;
    {hdmi_i2s_sck, hdmi_i2s_ws, hdmi_i2s_sd, link_detected, link_caps_done, tx_running} = '0;
    {remote_locked, input_detected, tx_mode_settled, tx_port_mode} = '0;
    {tmds_recovering, hdmi_pll_locked, input_frequency_settled_raw} = '0;
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'h0;
    t_reset;
    t_cfg;
    t_i2s;
    t_events;
    t_status;
    wrap_up;
  end

  // whole run is a few hundred cycles
  initial
  begin
    repeat (5000) @(posedge core_clk);
    errors++;
    wrap_up;
  end
endmodule // alsr_audio_link_regs_tb_top
